// ===== wvs_pkg.sv
package wvs_pkg;
    // register offsets on the byte-wide register port
    localparam logic [7:0] WVS_OFF_STATUS    = 8'h1c; // voice activity readback
    localparam logic [7:0] WVS_OFF_DATA_HI   = 8'h1d; // converter_data_high
    localparam logic [7:0] WVS_OFF_DATA_LO   = 8'h1e; // converter_data_low
    localparam logic [7:0] WVS_OFF_CTRL      = 8'h1f; // converter_source_control
    localparam logic [7:0] WVS_OFF_SEL       = 8'h20; // voice_select_trigger
    localparam logic [7:0] WVS_OFF_PITCH_HI  = 8'h21; // pitch_step_high
    localparam logic [7:0] WVS_OFF_PITCH_LO  = 8'h22; // pitch_step_low
    localparam logic [7:0] WVS_OFF_START_HI  = 8'h23; // sample_start_high
    localparam logic [7:0] WVS_OFF_START_LO  = 8'h24; // sample_start_low
    localparam logic [7:0] WVS_OFF_FMT_HI    = 8'h25; // format_loop_offset_high
    localparam logic [7:0] WVS_OFF_LOOP_LO   = 8'h26; // loop_offset_low
    localparam logic [7:0] WVS_OFF_ENV       = 8'h27; // decay_gain_high_bits
    localparam logic [7:0] WVS_OFF_LGAIN     = 8'h29; // left_gain_low
    localparam logic [7:0] WVS_OFF_RGAIN     = 8'h2a; // right_gain_low
    // field positions
    localparam int WVS_GAIN_ONLY_BIT  = 7; // gain_only_update in select register
    localparam int WVS_PITCH_ONLY_BIT = 6; // pitch_only_update in select register
    localparam int WVS_LEFT_SRC_BIT   = 2; // left_source_synth
    localparam int WVS_POWER_BIT      = 1; // converter_power
    localparam int WVS_RIGHT_SRC_BIT  = 0; // right_source_synth
    localparam int WVS_WIDTH_BIT      = 7; // sample_width_select
    localparam int WVS_LG_HI_LSB      = 4; // left_gain bits 9:8 in envelope register
    localparam int WVS_RG_HI_LSB      = 0; // right_gain bits 9:8 in envelope register
    // writable bit masks, all other bits read as zero
    localparam logic [7:0] WVS_MASK_CTRL = 8'h07;
    localparam logic [7:0] WVS_MASK_SEL  = 8'hc3;
    localparam logic [7:0] WVS_MASK_FMT  = 8'h9f;
    localparam logic [7:0] WVS_MASK_ENV  = 8'hb3;
    // values after reset
    localparam logic [7:0] WVS_REG_RST   = 8'h00;
    // sample format and addressing
    localparam int         WVS_VOICES     = 4;
    localparam int         WVS_FRAC_BITS  = 17;     // fraction bits of the phase
    localparam int         WVS_ALIGN_BITS = 5;      // start address alignment
    localparam logic [7:0] WVS_END_MARK   = 8'h80;  // end-of-section code
    localparam logic [9:0] WVS_GAIN_MIN   = 10'h3ff; // quietest attenuation
    // timing
    localparam longint WVS_CLK_HZ         = 125000000;
    localparam longint WVS_SAMPLE_RATE_HZ = 25000;
    localparam int     WVS_SAMPLE_CYC     = int'(WVS_CLK_HZ / WVS_SAMPLE_RATE_HZ);
    localparam int     WVS_DECAY_SAMPLES  = 64;     // output samples per decay step
    // fetch sequencer states
    typedef enum logic [2:0] {
        WVS_ST_IDLE = 3'b000,
        WVS_ST_ADR  = 3'b001,
        WVS_ST_B0   = 3'b010,
        WVS_ST_B1   = 3'b011,
        WVS_ST_MIX  = 3'b100
    } wvs_state_e;
    // register port request
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } wvs_bus_req_s;
    // programmed parameters of one voice
    typedef struct packed {
        logic [11:0] step;
        logic [3:0]  shift;
        logic [15:0] start;
        logic        wide;
        logic [12:0] loop;
        logic [9:0]  lg;
        logic [9:0]  rg;
    } wvs_voice_cfg_s;
    // running state of one voice
    typedef struct packed {
        logic        active;
        logic        looped;
        logic [17:0] pos;
        logic [16:0] frac;
        logic [9:0]  env;
    } wvs_voice_run_s;
endpackage : wvs_pkg

// ===== wvs_tick_div.sv
`timescale 1ns/1ps
// counts enabled cycles and pulses once every DIV of them
module wvs_tick_div
    import wvs_pkg::*;
#(
    parameter int DIV = 16
) (
    input  wire logic ref_clk,
    input  wire logic rst_b,
    input  wire logic en,
    output logic      tick
);
    localparam int CW = $clog2(DIV + 1);
    logic [CW-1:0] cnt_ff; // cycles counted so far
    logic          tick_ff; // registered pulse

    // wrap the counter and pulse on the last count
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            cnt_ff  <= '0;
            tick_ff <= 1'b0;
        end else begin
            tick_ff <= en && (cnt_ff == CW'(DIV - 1));
            if (en) begin
                cnt_ff <= (cnt_ff == CW'(DIV - 1)) ? '0 : cnt_ff + 1'b1;
            end
        end
    end

    assign tick = tick_ff;
endmodule : wvs_tick_div

// ===== wvs_gain_scale.sv
`timescale 1ns/1ps
// attenuates a sample by gain plus decay, 0 loudest and 3ff quietest
module wvs_gain_scale
    import wvs_pkg::*;
(
    input  wire logic signed [15:0] smp,
    input  wire logic        [9:0]  gain,
    input  wire logic        [9:0]  env,
    output logic signed      [15:0] scaled
);
    wire [10:0]        att_sum = {1'b0, gain} + {1'b0, env}; // total attenuation
    wire [9:0]         att     = att_sum[10] ? WVS_GAIN_MIN : att_sum[9:0];
    wire [9:0]         level   = WVS_GAIN_MIN - att; // linear loudness, 1024 steps
    wire signed [26:0] prod    = smp * $signed({1'b0, level});

    assign scaled = prod[25:10];
endmodule : wvs_gain_scale

// ===== wvs_synth.sv
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
// What this block does
// - select write picks voice, mode 00 starts it
// - mode 00 loads every parameter
// - mode 01 pitch only, 10 gains only
// - phase step is step over 2^(17-shift)
// - step 800h shift 6h plays each sample
// - fetch address is start times 32
// - width bit picks 8 or 12 bit
// - byte 80h marks section end
// - play once, then loop until silent
// - loop address is end plus offset
// - 10-bit left/right attenuation, 000h loudest
// - mcu source drives converter data bytes
// - build option and control pick converter use
// - control bit 1 powers converter, reset 0
// - bits 2/0 pick left/right source
// - control bits 7:3 read zero
// - unused 28h, 2bh-2fh read zero
module wvs_synth
    import wvs_pkg::*;
#(
    parameter int SAMPLE_DIV   = WVS_SAMPLE_CYC,
    parameter bit SYNTH_OPTION = 1'b1
) (
    input  wire logic                ref_clk,
    input  wire logic                rst_b,
    input  wire wvs_bus_req_s        bus,
    output logic [7:0]               rdata,
    output logic [17:0]              wave_rom_fetch_addr,
    input  wire logic [7:0]          rom_rdata,
    output logic                     converter_power,
    output logic signed [15:0]       dac_left,
    output logic signed [15:0]       dac_right
);
    // shadow registers written by software
    logic [7:0] data_hi_ff, data_lo_ff, ctrl_ff, sel_ff;
    logic [7:0] pitch_hi_ff, pitch_lo_ff, start_hi_ff, start_lo_ff;
    logic [7:0] fmt_hi_ff, loop_lo_ff, env_ff, lgain_ff, rgain_ff;
    logic [7:0] rdata_ff;                 // read answer, one cycle late

    // sequencer and mixing state
    wvs_state_e          state_ff, nxt_state;
    logic [1:0]          vsel_ff;         // voice being fetched
    logic [7:0]          byte0_ff;        // first fetched byte
    logic [17:0]         rom_addr_ff;     // address shown to the rom
    logic signed [17:0]  acc_l_ff, acc_r_ff;
    logic signed [15:0]  mix_l_ff, mix_r_ff;
    logic signed [15:0]  dac_l_ff, dac_r_ff;
    logic                decay_frame_ff;  // this frame applies a decay step

    // per voice storage
    wvs_voice_cfg_s cfg_ff [WVS_VOICES];
    wvs_voice_run_s run_ff [WVS_VOICES];

    // register write decode
    wire wr_hit    = bus.wr;
    wire trig_wr   = wr_hit && (bus.addr == WVS_OFF_SEL);
    wire [1:0] upd_mode = {bus.wdata[WVS_GAIN_ONLY_BIT], bus.wdata[WVS_PITCH_ONLY_BIT]};

    // converter control fields
    wire power_on  = ctrl_ff[WVS_POWER_BIT];
    wire left_syn  = ctrl_ff[WVS_LEFT_SRC_BIT] && SYNTH_OPTION;
    wire right_syn = ctrl_ff[WVS_RIGHT_SRC_BIT] && SYNTH_OPTION;
    wire synth_en  = power_on && (left_syn || right_syn);
    wire [15:0] converter_sample = {data_hi_ff, data_lo_ff};

    // parameter set assembled from the shadow registers
    wvs_voice_cfg_s new_cfg;
    assign new_cfg.step  = {pitch_hi_ff[3:0], pitch_lo_ff};
    assign new_cfg.shift = pitch_hi_ff[7:4];
    assign new_cfg.start = {start_hi_ff, start_lo_ff};
    assign new_cfg.wide  = fmt_hi_ff[WVS_WIDTH_BIT];
    assign new_cfg.loop  = {fmt_hi_ff[4:0], loop_lo_ff};
    assign new_cfg.lg    = {env_ff[WVS_LG_HI_LSB +: 2], lgain_ff};
    assign new_cfg.rg    = {env_ff[WVS_RG_HI_LSB +: 2], rgain_ff};

    // shadow register writes, unwritable bits forced to zero
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            {data_hi_ff, data_lo_ff, ctrl_ff, sel_ff} <= {4{WVS_REG_RST}};
            {pitch_hi_ff, pitch_lo_ff, start_hi_ff, start_lo_ff} <= {4{WVS_REG_RST}};
            {fmt_hi_ff, loop_lo_ff, env_ff, lgain_ff, rgain_ff} <= {5{WVS_REG_RST}};
        end else if (wr_hit) begin
            case (bus.addr)
                WVS_OFF_DATA_HI:  data_hi_ff  <= bus.wdata;
                WVS_OFF_DATA_LO:  data_lo_ff  <= bus.wdata;
                WVS_OFF_CTRL:     ctrl_ff     <= bus.wdata & WVS_MASK_CTRL;
                WVS_OFF_SEL:      sel_ff      <= bus.wdata & WVS_MASK_SEL;
                WVS_OFF_PITCH_HI: pitch_hi_ff <= bus.wdata;
                WVS_OFF_PITCH_LO: pitch_lo_ff <= bus.wdata;
                WVS_OFF_START_HI: start_hi_ff <= bus.wdata;
                WVS_OFF_START_LO: start_lo_ff <= bus.wdata;
                WVS_OFF_FMT_HI:   fmt_hi_ff   <= bus.wdata & WVS_MASK_FMT;
                WVS_OFF_LOOP_LO:  loop_lo_ff  <= bus.wdata;
                WVS_OFF_ENV:      env_ff      <= bus.wdata & WVS_MASK_ENV;
                WVS_OFF_LGAIN:    lgain_ff    <= bus.wdata;
                WVS_OFF_RGAIN:    rgain_ff    <= bus.wdata;
                default:          ; // unused and unmapped: write ignored
            endcase
        end
    end

    // voice activity for readback
    logic [3:0] active_vec, looped_vec;

    // read selection, anything unmapped or unused answers zero
    wire [7:0] rd_val =
        (bus.addr == WVS_OFF_STATUS)   ? {looped_vec, active_vec} :
        (bus.addr == WVS_OFF_DATA_HI)  ? data_hi_ff  :
        (bus.addr == WVS_OFF_DATA_LO)  ? data_lo_ff  :
        (bus.addr == WVS_OFF_CTRL)     ? ctrl_ff     :
        (bus.addr == WVS_OFF_SEL)      ? sel_ff      :
        (bus.addr == WVS_OFF_PITCH_HI) ? pitch_hi_ff :
        (bus.addr == WVS_OFF_PITCH_LO) ? pitch_lo_ff :
        (bus.addr == WVS_OFF_START_HI) ? start_hi_ff :
        (bus.addr == WVS_OFF_START_LO) ? start_lo_ff :
        (bus.addr == WVS_OFF_FMT_HI)   ? fmt_hi_ff   :
        (bus.addr == WVS_OFF_LOOP_LO)  ? loop_lo_ff  :
        (bus.addr == WVS_OFF_ENV)      ? env_ff      :
        (bus.addr == WVS_OFF_LGAIN)    ? lgain_ff    :
        (bus.addr == WVS_OFF_RGAIN)    ? rgain_ff    : 8'h00;

    // read data stands only in the cycle after the strobe
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= bus.rd ? rd_val : 8'h00;
        end
    end

    // output sample tick and slower decay tick
    logic sample_tick, decay_tick;
    wvs_tick_div #(.DIV(SAMPLE_DIV)) u_sample_div (
        .ref_clk (ref_clk),
        .rst_b   (rst_b),
        .en      (1'b1),
        .tick    (sample_tick)
    );
    wvs_tick_div #(.DIV(WVS_DECAY_SAMPLES)) u_decay_div (
        .ref_clk (ref_clk),
        .rst_b   (rst_b),
        .en      (sample_tick),
        .tick    (decay_tick)
    );

    // current voice view
    wvs_voice_cfg_s cur_cfg;
    wvs_voice_run_s cur_run;
    assign cur_cfg = cfg_ff[vsel_ff];
    assign cur_run = run_ff[vsel_ff];

    // byte address of the current sample, 12-bit pairs take three bytes
    wire [17:0] rom_base  = {cur_cfg.start[12:0], {WVS_ALIGN_BITS{1'b0}}};
    wire [17:0] pair_idx  = {1'b0, cur_run.pos[17:1]};
    wire [17:0] pair_off  = pair_idx + {pair_idx[16:0], 1'b0};
    wire [17:0] byte_off  = cur_cfg.wide ? pair_off + {17'h0, cur_run.pos[0]}
                                         : cur_run.pos;
    wire [17:0] addr0     = rom_base + byte_off;

    // decode the fetched bytes into a sample
    wire [11:0] smp12     = cur_run.pos[0] ? {byte0_ff[3:0], rom_rdata}
                                           : {byte0_ff, rom_rdata[7:4]};
    wire [7:0]  smp_top   = cur_cfg.wide ? smp12[11:4] : byte0_ff;
    wire        is_end    = (smp_top == WVS_END_MARK);
    wire signed [15:0] smp16 = cur_cfg.wide ? $signed({smp12, 4'h0})
                                            : $signed({byte0_ff, 8'h00});

    // loop point: end position plus offset, carry out of 13 bits dropped
    wire [12:0] loop_low  = cur_run.pos[12:0] + cur_cfg.loop;
    wire [17:0] loop_idx  = {cur_run.pos[17:13], loop_low};

    // phase advance: step shifted by octave over 2^17
    wire [34:0] phase_inc = 35'(cur_cfg.step) << cur_cfg.shift;
    wire [34:0] phase_nxt = {cur_run.pos, cur_run.frac} + phase_inc;

    // next running state of the voice just mixed
    wvs_voice_run_s nxt_run;
    always_comb begin
        nxt_run = cur_run;
        if (is_end) begin
            nxt_run.looped = 1'b1;
            nxt_run.pos    = loop_idx;
            nxt_run.frac   = '0;
        end else begin
            nxt_run.pos    = phase_nxt[34:17];
            nxt_run.frac   = phase_nxt[16:0];
        end
        if (cur_run.looped && decay_frame_ff) begin
            if (cur_run.env == WVS_GAIN_MIN) begin
                nxt_run.active = 1'b0;
            end else begin
                nxt_run.env = cur_run.env + 10'h001;
            end
        end
    end

    wire mix_upd = (state_ff == WVS_ST_MIX) && cur_run.active;

    // per voice parameter and run state
    for (genvar g = 0; g < WVS_VOICES; g++) begin : g_voice
        wire trig_g = trig_wr && (bus.wdata[1:0] == 2'(g));
        always_ff @(posedge ref_clk) begin
            if (!rst_b) begin
                cfg_ff[g] <= '0;
                run_ff[g] <= '0;
            end else if (trig_g) begin
                case (upd_mode)
                    2'b00: begin
                        cfg_ff[g]        <= new_cfg;
                        run_ff[g]        <= '0;
                        run_ff[g].active <= 1'b1;
                    end
                    2'b01: begin
                        cfg_ff[g].step  <= new_cfg.step;
                        cfg_ff[g].shift <= new_cfg.shift;
                    end
                    2'b10: begin
                        cfg_ff[g].lg <= new_cfg.lg;
                        cfg_ff[g].rg <= new_cfg.rg;
                    end
                    default: ; // both bits set: nothing is updated
                endcase
            end else if (mix_upd && (vsel_ff == 2'(g))) begin
                run_ff[g] <= nxt_run;
            end
        end
        assign active_vec[g] = run_ff[g].active;
        assign looped_vec[g] = run_ff[g].looped;
    end

    // per side attenuation of the current sample
    logic signed [15:0] scaled_l, scaled_r;
    wvs_gain_scale u_gain_l (
        .smp    (smp16),
        .gain   (cur_cfg.lg),
        .env    (cur_run.env),
        .scaled (scaled_l)
    );
    wvs_gain_scale u_gain_r (
        .smp    (smp16),
        .gain   (cur_cfg.rg),
        .env    (cur_run.env),
        .scaled (scaled_r)
    );

    // accumulate this voice, silent if idle or at an end marker
    wire               voice_on = cur_run.active && !is_end;
    wire signed [17:0] add_l    = voice_on ? 18'(scaled_l) : 18'sh0;
    wire signed [17:0] add_r    = voice_on ? 18'(scaled_r) : 18'sh0;
    wire signed [17:0] sum_l    = acc_l_ff + add_l;
    wire signed [17:0] sum_r    = acc_r_ff + add_r;

    // clamp a wide sum to 16 bits
    function automatic logic signed [15:0] sat16(input logic signed [17:0] v);
        if (v > 18'sh07fff) begin
            sat16 = 16'sh7fff;
        end else if (v < -18'sh08000) begin
            sat16 = -16'sh8000;
        end else begin
            sat16 = v[15:0];
        end
    endfunction : sat16

    // sequencer next state
    wire last_voice = (vsel_ff == 2'(WVS_VOICES - 1));
    always_comb begin
        case (state_ff)
            WVS_ST_IDLE: nxt_state = (sample_tick && synth_en) ? WVS_ST_ADR : WVS_ST_IDLE;
            WVS_ST_ADR:  nxt_state = WVS_ST_B0;
            WVS_ST_B0:   nxt_state = WVS_ST_B1;
            WVS_ST_B1:   nxt_state = WVS_ST_MIX;
            WVS_ST_MIX:  nxt_state = last_voice ? WVS_ST_IDLE : WVS_ST_ADR;
            default:     nxt_state = WVS_ST_IDLE;
        endcase
    end

    // fetch two bytes per voice, mix, and latch the frame on the last voice
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            state_ff       <= WVS_ST_IDLE;
            vsel_ff        <= 2'h0;
            byte0_ff       <= 8'h00;
            rom_addr_ff    <= 18'h00000;
            acc_l_ff       <= 18'sh0;
            acc_r_ff       <= 18'sh0;
            mix_l_ff       <= 16'sh0;
            mix_r_ff       <= 16'sh0;
            decay_frame_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            if (decay_tick) begin
                decay_frame_ff <= 1'b1;
            end else if (state_ff == WVS_ST_IDLE) begin
                decay_frame_ff <= 1'b0;
            end
            case (state_ff)
                WVS_ST_IDLE: begin
                    vsel_ff  <= 2'h0;
                    acc_l_ff <= 18'sh0;
                    acc_r_ff <= 18'sh0;
                end
                WVS_ST_ADR: rom_addr_ff <= addr0;
                WVS_ST_B0:  rom_addr_ff <= addr0 + 18'h00001;
                WVS_ST_B1:  byte0_ff    <= rom_rdata;
                WVS_ST_MIX: begin
                    acc_l_ff <= sum_l;
                    acc_r_ff <= sum_r;
                    vsel_ff  <= vsel_ff + 2'h1;
                    if (last_voice) begin
                        mix_l_ff <= sat16(sum_l);
                        mix_r_ff <= sat16(sum_r);
                    end
                end
                default: ;
            endcase
        end
    end

    // converter feed: powered off gives zero, each side picks its source
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            dac_l_ff <= 16'sh0;
            dac_r_ff <= 16'sh0;
        end else begin
            dac_l_ff <= !power_on ? 16'sh0 : left_syn  ? mix_l_ff
                                           : $signed(converter_sample);
            dac_r_ff <= !power_on ? 16'sh0 : right_syn ? mix_r_ff
                                           : $signed(converter_sample);
        end
    end

    assign rdata               = rdata_ff;
    assign wave_rom_fetch_addr = rom_addr_ff;
    assign converter_power     = power_on;
    assign dac_left            = dac_l_ff;
    assign dac_right           = dac_r_ff;

    // checks on the design's own behaviour
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    property p_trig_start;
        trig_wr && (upd_mode == 2'b00) |=> run_ff[$past(bus.wdata[1:0])].active;
    endproperty
    a_trig_start: assert property (p_trig_start) else $error("voice not started");

    property p_pitch_only;
        trig_wr && (upd_mode == 2'b01) && (bus.wdata[1:0] == 2'h0)
            |=> (cfg_ff[0].step == $past(new_cfg.step)) && $stable(cfg_ff[0].lg);
    endproperty
    a_pitch_only: assert property (p_pitch_only) else $error("pitch-only update wrong");

    property p_addr_base;
        (state_ff == WVS_ST_ADR) && (cur_run.pos == 18'h0)
            |=> wave_rom_fetch_addr == {$past(cur_cfg.start[12:0]), 5'h00};
    endproperty
    a_addr_base: assert property (p_addr_base) else $error("fetch address not start*32");

    property p_unit_step;
        mix_upd && !trig_wr && !is_end && (cur_cfg.step == 12'h800) && (cur_cfg.shift == 4'h6)
            |=> run_ff[$past(vsel_ff)].pos == $past(cur_run.pos) + 18'h1;
    endproperty
    a_unit_step: assert property (p_unit_step) else $error("unit pitch did not step one");

    property p_loop_jump;
        mix_upd && !trig_wr && is_end |=> run_ff[$past(vsel_ff)].pos == $past(loop_idx);
    endproperty
    a_loop_jump: assert property (p_loop_jump) else $error("end marker did not loop");

    property p_ctrl_zero;
        bus.rd && (bus.addr == WVS_OFF_CTRL) |=> rdata[7:3] == 5'h00;
    endproperty
    a_ctrl_zero: assert property (p_ctrl_zero) else $error("control high bits not zero");

    property p_unused_zero;
        bus.rd && ((bus.addr == 8'h28) || (bus.addr >= 8'h2b && bus.addr <= 8'h2f))
            |=> rdata == 8'h00;
    endproperty
    a_unused_zero: assert property (p_unused_zero) else $error("unused read not zero");

    property p_mcu_left;
        power_on && !left_syn |=> dac_left == $past($signed(converter_sample));
    endproperty
    a_mcu_left: assert property (p_mcu_left) else $error("left not from mcu data");
endmodule : wvs_synth

// ===== wvs_rom_model.sv
`timescale 1ns/1ps
// wave rom stand-in: one-cycle read latency
module wvs_rom_model
    import wvs_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic [17:0] addr,
    output logic      [7:0]  data
);
    // sections start on 32-byte bounds, end code at offset 15
    always_ff @(posedge ref_clk) begin
        if (addr[4:0] == 5'h0f) begin
            data <= 8'h80;
        end else begin
            data <= {1'b0, addr[6:0]};
        end
    end
endmodule : wvs_rom_model

// ===== tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import wvs_pkg::*;
    logic               ref_clk;     // system clock
    logic               rst_b;       // sync reset
    wvs_bus_req_s       bus;         // register request
    logic        [7:0]  rdata;       // read data
    logic        [7:0]  rom_d;       // rom byte
    logic        [17:0] fa;          // rom fetch address
    logic        [17:0] lst = '0;    // last seen address
    logic               pwr;         // converter power
    logic signed [15:0] dl;          // left sample
    logic signed [15:0] dr;          // right sample
    logic        [31:0] lfsr;        // random source
    logic        [17:0] aq[$];       // fetched addresses of voice 0
    int                 n_mismatch;  // mismatches
    int                 checks_done; // comparisons
    int                 cyc;         // cycle count
    wvs_synth #(.SAMPLE_DIV(40)) dut_u (.ref_clk(ref_clk), .rst_b(rst_b), .bus(bus),
        .rdata(rdata), .wave_rom_fetch_addr(fa), .rom_rdata(rom_d),
        .converter_power(pwr), .dac_left(dl), .dac_right(dr));
    wvs_rom_model rom_u (.ref_clk(ref_clk), .addr(fa), .data(rom_d));
    // clock
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    // record fetch addresses in the 32..63 section and cut hangs short
    // sampled mid-cycle, away from the edge that launches the address
    always @(negedge ref_clk) begin
        if (fa != lst && fa[17:5] == 13'h1) aq.push_back(fa);
        lst = fa;
        cyc++;
        if (cyc == 6000) begin
            n_mismatch++;
            complete_run();
        end
    end
    function automatic logic [31:0] lfsr_next(logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr_next
    // bits that read back after a write
    function automatic logic [7:0] msk(int a);
        case (a)
            'h1f: return 8'h07;
            'h20: return 8'hc3;
            'h25: return 8'h9f;
            'h27: return 8'hb3;
            'h28, 'h2b, 'h2c, 'h2d, 'h2e, 'h2f: return 8'h00;
            default: return 8'hff;
        endcase
    endfunction : msk
    task automatic cmp(logic [17:0] got, logic [17:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    // one bus access; a read is checked in the following cycle
    task automatic acc(bit w, int a, logic [7:0] d, logic [7:0] exp);
        bus <= '{wr: w, rd: !w, addr: a[7:0], wdata: d};
        @(posedge ref_clk);
        bus <= '0;
        @(negedge ref_clk);
        if (!w) cmp(rdata, exp);
        @(posedge ref_clk);
    endtask : acc
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : complete_run
    // main sequence
    initial begin
        bus = '0;
        rst_b = 1'b0;
        lfsr = 32'hecb32b00;
        repeat (3) @(posedge ref_clk);
        rst_b <= 1'b1;
        @(posedge ref_clk);
        cmp(pwr, 0);
        for (int a = 'h1d; a <= 'h2f; a++) acc(0, a, 0, 0);
        for (int a = 'h1d; a <= 'h2f; a++) begin
            lfsr = lfsr_next(lfsr);
            acc(1, a, lfsr[7:0], 0);
            acc(0, a, 0, lfsr[7:0] & msk(a));
        end
        $display("register test done");
        lfsr = lfsr_next(lfsr);
        acc(1, 'h1d, lfsr[15:8], 0);
        acc(1, 'h1e, lfsr[7:0], 0);
        acc(1, 'h1f, 8'h02, 0);
        @(negedge ref_clk);
        cmp(pwr, 1);
        cmp(dl, {{2{lfsr[15]}}, lfsr[15:0]});
        cmp(dr, {{2{lfsr[15]}}, lfsr[15:0]});
        @(posedge ref_clk);
        acc(1, 'h1f, 8'h06, 0);
        @(negedge ref_clk);
        cmp(dr, {{2{lfsr[15]}}, lfsr[15:0]});
        @(posedge ref_clk);
        acc(1, 'h1f, 8'h00, 0);
        @(negedge ref_clk);
        cmp(pwr, 0);
        cmp(dl, 0);
        @(posedge ref_clk);
        $display("converter test done");
        // voice 0: step 800h shift 6h, start 1, 8-bit, loudest, repeat length 15
        acc(1, 'h21, 8'h68, 0);
        acc(1, 'h22, 8'h00, 0);
        acc(1, 'h23, 8'h00, 0);
        acc(1, 'h24, 8'h01, 0);
        acc(1, 'h25, 8'h1f, 0);
        acc(1, 'h26, 8'hf1, 0);
        acc(1, 'h27, 8'h00, 0);
        acc(1, 'h29, 8'h00, 0);
        acc(1, 'h2a, 8'h00, 0);
        acc(1, 'h20, 8'h00, 0);
        // frames start only once the source is enabled, so the first fetch is clean
        aq.delete();
        acc(1, 'h1f, 8'h07, 0);
        repeat (1000) @(posedge ref_clk);
        // sixteen samples up to the end code, then back to the loop point
        for (int k = 0; k < 34; k++) begin
            cmp(aq[k], 18'd32 + 18'(((k % 32) + 1) / 2));
        end
        $display("playback test done");
        // pitch-only then gain-only update of voice 0, select keeps its mask
        acc(1, 'h21, 8'h78, 0);
        acc(1, 'h20, 8'h40, 0);
        acc(1, 'h20, 8'h80, 0);
        acc(0, 'h20, 0, 8'h80);
        $display("update mode test done");
        complete_run();
    end
endmodule : tb_top
